//--- include/qdsr_cfg.svh
// Offsets, reset values and timing counts for the demodulator status readout.
`ifndef QDSR_CFG_SVH
`define QDSR_CFG_SVH
`define QDSR_ADR_EV_HIGH   7'h00
`define QDSR_ADR_EV_MID    7'h01
`define QDSR_ADR_EV_LOW    7'h02
`define QDSR_ADR_ST_HIGH   7'h04
`define QDSR_ADR_ST_LOW    7'h05
`define QDSR_ADR_IE_HIGH   7'h1C
`define QDSR_ADR_IE_MID    7'h1D
`define QDSR_ADR_IE_LOW    7'h1E
`define QDSR_ADR_PROBE_SEL 7'h67
`define QDSR_ADR_SR_HIGH   7'h74
`define QDSR_ADR_SR_LOW    7'h75
`define QDSR_ADR_PV_HIGH   7'h7B
`define QDSR_ADR_PV_LOW    7'h7C
`define QDSR_RST_BYTE      8'h00
`define QDSR_RST_SEL       4'h0
`define QDSR_SEL_IQ        4'h0
`define QDSR_SEL_DC        4'h1
`define QDSR_SEL_DEC       4'h5
`define QDSR_SEL_FLD       4'h6
`define QDSR_SEL_TLD       4'h7
`define QDSR_SEL_PLD       4'h8
`define QDSR_NUM_RANGES    12
`define QDSR_CLK_NS        50
`define QDSR_LOCK_TICK_NS  1000
`define QDSR_LOCK_TICK_CYC (`QDSR_LOCK_TICK_NS / `QDSR_CLK_NS)
`endif

//--- include/qdsr_pkg.sv
// Types shared by the demodulator status readout.
package qdsr_pkg;
	typedef enum logic [2:0] {
		QDSR_SEARCH  = 3'b001,
		QDSR_CT_WAIT = 3'b010,
		QDSR_LOCKED  = 3'b100
	} qdsr_lock_state_t;
endpackage : qdsr_pkg

//--- design/qdsr_scan.sv
// Symbol-rate sub-range scan sequencer.
`timescale 1ns/1ns
`include "qdsr_cfg.svh"
module qdsr_scan (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        scan_start,
	input  wire logic        search_rates,
	input  wire logic [11:0] subrange_select,
	input  wire logic        sweep_done,
	output logic      [3:0]  active_subrange,
	output logic             freq_end,
	output logic             rate_end
);
	logic [3:0] subrange_ff;
	logic [3:0] nxt_subrange;
	logic [4:0] top_pick;
	logic [4:0] below_pick;

	// Returns found flag and index of the highest selected sub-range below lim.
	function automatic logic [4:0] qdsr_pick(input logic [11:0] sel, input logic [4:0] lim);
		logic [4:0] res;
		res = 5'h00;
		for (int i = 0; i < `QDSR_NUM_RANGES; i++) begin
			if (sel[i] && (i < int'(lim))) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction : qdsr_pick

	assign top_pick   = qdsr_pick(subrange_select, 5'h0C);
	assign below_pick = qdsr_pick(subrange_select, {1'b0, subrange_ff});
	assign freq_end   = sweep_done;
	assign rate_end   = sweep_done && search_rates && !below_pick[4];
	assign nxt_subrange = scan_start ? top_pick[3:0] :
		(sweep_done && search_rates) ? (below_pick[4] ? below_pick[3:0] : top_pick[3:0]) :
		subrange_ff;
	assign active_subrange = subrange_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			subrange_ff <= 4'h0;
		end else begin
			subrange_ff <= nxt_subrange;
		end
	end

	chk_known_rate_end: assert property (@(posedge clk) disable iff (!rst_n)
		!search_rates |-> !rate_end) else $error("Rate end raised with known symbol rate.");
	chk_descend_order: assert property (@(posedge clk) disable iff (!rst_n)
		(sweep_done && search_rates && !scan_start && below_pick[4])
		|=> active_subrange < $past(active_subrange))
		else $error("Sub-range scan did not descend.");
	chk_wrap_top: assert property (@(posedge clk) disable iff (!rst_n)
		(rate_end && !scan_start) |=> active_subrange == $past(top_pick[3:0]))
		else $error("Scan did not wrap to highest sub-range.");
endmodule : qdsr_scan

//--- design/qdsr_status.sv
// Demodulator event, status, symbol-rate and probe readout registers.
// Operation
// - Reading an event register returns it, then clears it.
// - High event byte: lock and loss of CT, full, timing, carrier lock.
// - After CT lock wait programmed time; full lock only on decoder lock.
// - Decoder lock timeout drops CT lock and resumes searching.
// - Middle event byte: gain, frequency lock, calc done, sweep maxima.
// - Low event byte: state change, range ends, AFC, searches, loop limit.
// - Known rate: sweep raises frequency end, restarts, no rate end.
// - Unknown rate: search each selected sub-range of twelve.
// - Start at highest selected sub-range, descend, frequency end each.
// - After last sub-range raise rate end and wrap, forever.
// - High status byte shows live quality and lock levels.
// - Low status byte shows sweep activity; bits 5 to 0 reserved.
// - Sixteen-bit symbol-rate readout spans two byte registers.
// - Probe select 1 shows I and Q DC offsets.
// - Probe select 5 puts decimation index in bits 15 to 13.
// - Probe select 6 shows frequency detector byte in both bytes.
// - Probe select 7 shows timing detector; reading does not reset.
// - Probe select 8 shows phase detector; reading does not reset.
// - Probe can snapshot I and Q of one symbol.
// - Enable registers gate events onto interrupt pin only.
`timescale 1ns/1ns
`include "qdsr_cfg.svh"
module qdsr_status (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        reg_rd_en,
	input  wire logic        reg_wr_en,
	input  wire logic [6:0]  reg_addr,
	input  wire logic [7:0]  reg_wr_data,
	output logic      [7:0]  reg_rd_data,
	output logic             reg_rd_valid,
	input  wire logic        ct_acquired,
	input  wire logic        decoder_lock,
	input  wire logic [7:0]  lock_wait_limit,
	input  wire logic        timing_lock,
	input  wire logic        carrier_lock,
	input  wire logic        timing_gain_lock,
	input  wire logic        frequency_lock,
	input  wire logic        front_end_gain_lock,
	input  wire logic        quality_hi_bit,
	input  wire logic        quality_lo_bit,
	input  wire logic        timing_sweep_on,
	input  wire logic        carrier_sweep_on,
	input  wire logic        calc_done,
	input  wire logic        timing_sweep_max,
	input  wire logic        carrier_sweep_max,
	input  wire logic        afc_success,
	input  wire logic        afc_fail,
	input  wire logic        next_freq_search,
	input  wire logic        same_freq_search,
	input  wire logic        loop_limit,
	input  wire logic        scan_start,
	input  wire logic        search_rates,
	input  wire logic [11:0] subrange_select,
	input  wire logic        sweep_done,
	input  wire logic [15:0] symbol_rate_readout,
	input  wire logic [7:0]  inphase_offset,
	input  wire logic [7:0]  quadrature_offset,
	input  wire logic [2:0]  decimation_index,
	input  wire logic [7:0]  freq_detector_value,
	input  wire logic [15:0] timing_detector_value,
	input  wire logic [15:0] phase_detector_value,
	input  wire logic [7:0]  symbol_i,
	input  wire logic [7:0]  symbol_q,
	output logic             demod_full_lock,
	output logic             carrier_timing_lock,
	output logic             resume_search,
	output logic      [3:0]  active_subrange,
	output logic             freq_restart,
	output logic             irq_n
);
	localparam logic [6:0] EV_ADR [0:2] = '{`QDSR_ADR_EV_LOW, `QDSR_ADR_EV_MID, `QDSR_ADR_EV_HIGH};
	localparam logic [6:0] IE_ADR [0:2] = '{`QDSR_ADR_IE_LOW, `QDSR_ADR_IE_MID, `QDSR_ADR_IE_HIGH};
	localparam logic [4:0] TICK_LAST = 5'(`QDSR_LOCK_TICK_CYC - 1);

	qdsr_pkg::qdsr_lock_state_t state_ff;
	qdsr_pkg::qdsr_lock_state_t nxt_state;
	logic [4:0]  tick_ff;
	logic [7:0]  wait_ff;
	logic [7:0]  nxt_wait;
	logic        tick;
	logic        timeout;
	logic [9:0]  lvl_ff;
	logic [9:0]  lvl_now;
	logic [9:0]  rise;
	logic [9:0]  fall;
	logic        freq_end;
	logic        rate_end;
	logic        state_change;
	logic [23:0] ev_set;
	logic [23:0] ev_ff;
	logic [23:0] ie_ff;
	logic [2:0]  ev_rd_hit;
	logic [3:0]  probe_sel_ff;
	logic [7:0]  snap_q_ff;
	logic [7:0]  rd_data_ff;
	logic        rd_valid_ff;
	logic        irq_n_ff;
	logic [7:0]  status_high;
	logic [7:0]  status_low;
	logic [15:0] probe_word;
	logic        probe_snap;
	logic [7:0]  probe_low;
	logic [7:0]  rd_mux;

	// Lock sequencing: CT lock waits for decoder lock, timeout resumes search.
	assign tick    = (tick_ff == TICK_LAST);
	assign timeout = (state_ff == qdsr_pkg::QDSR_CT_WAIT) && !decoder_lock && tick &&
		(wait_ff == lock_wait_limit);
	assign nxt_wait = (state_ff != qdsr_pkg::QDSR_CT_WAIT) ? 8'h00 :
		(tick && (wait_ff != lock_wait_limit)) ? wait_ff + 8'h01 : wait_ff;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			qdsr_pkg::QDSR_SEARCH: begin
				if (ct_acquired) begin
					nxt_state = qdsr_pkg::QDSR_CT_WAIT;
				end
			end
			qdsr_pkg::QDSR_CT_WAIT: begin
				if (!ct_acquired || timeout) begin
					nxt_state = qdsr_pkg::QDSR_SEARCH;
				end else if (decoder_lock) begin
					nxt_state = qdsr_pkg::QDSR_LOCKED;
				end
			end
			qdsr_pkg::QDSR_LOCKED: begin
				if (!ct_acquired || !decoder_lock) begin
					nxt_state = qdsr_pkg::QDSR_SEARCH;
				end
			end
			default: begin
				nxt_state = qdsr_pkg::QDSR_SEARCH;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= qdsr_pkg::QDSR_SEARCH;
			tick_ff  <= 5'h00;
			wait_ff  <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			tick_ff  <= tick ? 5'h00 : tick_ff + 5'h01;
			wait_ff  <= nxt_wait;
		end
	end

	assign demod_full_lock     = (state_ff == qdsr_pkg::QDSR_LOCKED);
	assign carrier_timing_lock = (state_ff != qdsr_pkg::QDSR_SEARCH);
	assign resume_search       = timeout;
	assign state_change        = (nxt_state != state_ff);

	qdsr_scan u_scan (
		.clk             (clk),
		.rst_n           (rst_n),
		.scan_start      (scan_start),
		.search_rates    (search_rates),
		.subrange_select (subrange_select),
		.sweep_done      (sweep_done),
		.active_subrange (active_subrange),
		.freq_end        (freq_end),
		.rate_end        (rate_end)
	);
	assign freq_restart = sweep_done;

	// Edge detection of lock levels for the lock and loss events.
	assign lvl_now = {carrier_timing_lock, demod_full_lock, timing_lock, carrier_lock,
		front_end_gain_lock, timing_gain_lock, frequency_lock, 3'b000};
	assign rise = lvl_now & ~lvl_ff;
	assign fall = ~lvl_now & lvl_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_ff <= 10'h000;
		end else begin
			lvl_ff <= lvl_now;
		end
	end

	assign ev_set[23:16] = {rise[9], fall[9], rise[8], fall[8],
		rise[7], fall[7], rise[6], fall[6]};
	assign ev_set[15:8]  = {rise[5], rise[4], fall[4], rise[3], fall[3],
		calc_done, timing_sweep_max, carrier_sweep_max};
	assign ev_set[7:0]   = {state_change, freq_end, rate_end, afc_success, afc_fail,
		next_freq_search, same_freq_search, loop_limit};

	// Event and enable byte registers.
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_byte
			assign ev_rd_hit[g] = reg_rd_en && (reg_addr == EV_ADR[g]);
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					ev_ff[8*g+:8] <= `QDSR_RST_BYTE;
					ie_ff[8*g+:8] <= `QDSR_RST_BYTE;
				end else begin
					ev_ff[8*g+:8] <= (ev_rd_hit[g] ? 8'h00 : ev_ff[8*g+:8]) |
						ev_set[8*g+:8];
					if (reg_wr_en && (reg_addr == IE_ADR[g])) begin
						ie_ff[8*g+:8] <= reg_wr_data;
					end
				end
			end
		end
	endgenerate

	// Live status, probe selection and read mux.
	assign status_high = {quality_hi_bit, quality_lo_bit, frequency_lock, timing_gain_lock,
		timing_lock, carrier_lock, carrier_timing_lock, demod_full_lock};
	assign status_low  = {timing_sweep_on, carrier_sweep_on, 6'h00};
	assign probe_word  =
		(probe_sel_ff == `QDSR_SEL_IQ)  ? {symbol_i, snap_q_ff} :
		(probe_sel_ff == `QDSR_SEL_DC)  ? {inphase_offset, quadrature_offset} :
		(probe_sel_ff == `QDSR_SEL_DEC) ? {decimation_index, 13'h0000} :
		(probe_sel_ff == `QDSR_SEL_FLD) ? {freq_detector_value, freq_detector_value} :
		(probe_sel_ff == `QDSR_SEL_TLD) ? timing_detector_value :
		(probe_sel_ff == `QDSR_SEL_PLD) ? phase_detector_value : 16'h0000;
	assign probe_snap = reg_rd_en && (reg_addr == `QDSR_ADR_PV_HIGH) &&
		(probe_sel_ff == `QDSR_SEL_IQ);
	assign probe_low  = probe_word[7:0];

	assign rd_mux =
		(reg_addr == `QDSR_ADR_EV_HIGH)   ? ev_ff[23:16] :
		(reg_addr == `QDSR_ADR_EV_MID)    ? ev_ff[15:8] :
		(reg_addr == `QDSR_ADR_EV_LOW)    ? ev_ff[7:0] :
		(reg_addr == `QDSR_ADR_ST_HIGH)   ? status_high :
		(reg_addr == `QDSR_ADR_ST_LOW)    ? status_low :
		(reg_addr == `QDSR_ADR_IE_HIGH)   ? ie_ff[23:16] :
		(reg_addr == `QDSR_ADR_IE_MID)    ? ie_ff[15:8] :
		(reg_addr == `QDSR_ADR_IE_LOW)    ? ie_ff[7:0] :
		(reg_addr == `QDSR_ADR_PROBE_SEL) ? {4'h0, probe_sel_ff} :
		(reg_addr == `QDSR_ADR_SR_HIGH)   ? symbol_rate_readout[15:8] :
		(reg_addr == `QDSR_ADR_SR_LOW)    ? symbol_rate_readout[7:0] :
		(reg_addr == `QDSR_ADR_PV_HIGH)   ? probe_word[15:8] :
		(reg_addr == `QDSR_ADR_PV_LOW)    ? probe_low : 8'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			probe_sel_ff <= `QDSR_RST_SEL;
			snap_q_ff    <= `QDSR_RST_BYTE;
			rd_data_ff   <= `QDSR_RST_BYTE;
			rd_valid_ff  <= 1'b0;
			irq_n_ff     <= 1'b1;
		end else begin
			if (reg_wr_en && (reg_addr == `QDSR_ADR_PROBE_SEL)) begin
				probe_sel_ff <= reg_wr_data[3:0];
			end
			if (probe_snap) begin
				snap_q_ff <= symbol_q;
			end
			if (reg_rd_en) begin
				rd_data_ff <= rd_mux;
			end
			rd_valid_ff <= reg_rd_en;
			irq_n_ff    <= ~|(ev_ff & ie_ff);
		end
	end

	assign reg_rd_data  = rd_data_ff;
	assign reg_rd_valid = rd_valid_ff;
	assign irq_n        = irq_n_ff;

	chk_clear_on_read: assert property (@(posedge clk) disable iff (!rst_n)
		(ev_rd_hit[2] && ev_set[23:16] == 8'h00) |=> ev_ff[23:16] == 8'h00)
		else $error("Event byte not cleared by read.");
	chk_set_beats_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(ev_rd_hit[1] && ev_set[15:8] != 8'h00) |=> ev_ff[15:8] == $past(ev_set[15:8]))
		else $error("Event lost during clearing read.");
	chk_read_returns_ev: assert property (@(posedge clk) disable iff (!rst_n)
		ev_rd_hit[1] |=> reg_rd_data == $past(ev_ff[15:8]))
		else $error("Event read returned wrong contents.");
	chk_full_needs_dec: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(demod_full_lock) |-> $past(decoder_lock) && $past(carrier_timing_lock))
		else $error("Full lock without decoder lock.");
	chk_wait_timeout: assert property (@(posedge clk) disable iff (!rst_n)
		timeout |=> !carrier_timing_lock ##1 ev_ff[22])
		else $error("Timeout did not drop CT lock.");
	chk_status_high: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd_en && reg_addr == `QDSR_ADR_ST_HIGH) |=> reg_rd_data == $past(status_high))
		else $error("Status high read mismatch.");
	chk_status_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd_en && reg_addr == `QDSR_ADR_ST_LOW) |=> reg_rd_data[5:0] == 6'h00)
		else $error("Reserved status bits not zero.");
	chk_probe_dec: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd_en && reg_addr == `QDSR_ADR_PV_HIGH && probe_sel_ff == `QDSR_SEL_DEC)
		|=> reg_rd_data == {$past(decimation_index), 5'h00})
		else $error("Decimation index misplaced.");
	chk_probe_fld: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd_en && reg_addr == `QDSR_ADR_PV_LOW && probe_sel_ff == `QDSR_SEL_FLD)
		|=> reg_rd_data == $past(freq_detector_value))
		else $error("Frequency detector byte mismatch.");
	chk_irq_gating: assert property (@(posedge clk) disable iff (!rst_n)
		(ie_ff == 24'h000000) |=> irq_n)
		else $error("Interrupt asserted with all enables clear.");
endmodule : qdsr_status

//--- tb/qdsr_host.sv
// Host model that reads and writes the readout registers one strobe at a time.
`timescale 1ns/1ns
module qdsr_host (
	input  wire logic       clk,
	output logic            reg_rd_en,
	output logic            reg_wr_en,
	output logic      [6:0] reg_addr,
	output logic      [7:0] reg_wr_data,
	input  wire logic [7:0] reg_rd_data,
	input  wire logic       reg_rd_valid
);
	initial begin
		reg_rd_en   = 1'b0;
		reg_wr_en   = 1'b0;
		reg_addr    = 7'h55;
		reg_wr_data = 8'hAA;
	end
	// The strobe lasts one cycle, because a second cycle would clear an event byte again.
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
		@(negedge clk);
		reg_rd_en = 1'b1;
		reg_addr  = a;
		@(negedge clk);
		reg_rd_en = 1'b0;
		reg_addr  = ~a;
		d = reg_rd_data;
		v = reg_rd_valid;
	endtask : rd
	// Only documented probe selects and the low enable byte are written by the bench through this task.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr_en   = 1'b1;
		reg_addr    = a;
		reg_wr_data = d;
		@(negedge clk);
		reg_wr_en   = 1'b0;
		reg_addr    = ~a;
		reg_wr_data = ~d;
	endtask : wr
	// Rate setting for reacquisition keeps the top fourteen readout bits.
	function automatic logic [13:0] rate_setting(input logic [15:0] r);
		return r[15:2];
	endfunction : rate_setting
endmodule : qdsr_host

//--- tb/qdsr_status_test.sv
// Self-checking bench for the demodulator status readout.
`timescale 1ns/1ns
`include "qdsr_cfg.svh"
module qdsr_status_test;
	logic        clk, rst_n, ct_acq, dec_lock, srch, scan_go, swp;
	logic [11:0] sel12;
	logic [7:0]  ev, lim, dci, dcq, fld, sym_i, sym_q;
	logic [9:0]  lv;
	logic [15:0] srate, tld, pld;
	logic [2:0]  dec;
	logic        rd_en, wr_en, rvalid, full_lock, ct_lock, resume, frs, irq_n;
	logic [6:0]  addr;
	logic [7:0]  wdata, rdata;
	logic [3:0]  act;
	int          err_count = 0;
	int          n_checks = 0;

	qdsr_host u_host (.clk(clk), .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_addr(addr),
		.reg_wr_data(wdata), .reg_rd_data(rdata), .reg_rd_valid(rvalid));

	qdsr_status u_dut (.clk(clk), .rst_n(rst_n), .reg_rd_en(rd_en), .reg_wr_en(wr_en),
		.reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata), .reg_rd_valid(rvalid),
		.ct_acquired(ct_acq), .decoder_lock(dec_lock), .lock_wait_limit(lim),
		.timing_lock(lv[5]), .carrier_lock(lv[4]), .timing_gain_lock(lv[6]),
		.frequency_lock(lv[7]), .front_end_gain_lock(lv[3]), .quality_hi_bit(lv[9]),
		.quality_lo_bit(lv[8]), .timing_sweep_on(lv[2]), .carrier_sweep_on(lv[1]),
		.calc_done(ev[7]), .timing_sweep_max(ev[6]), .carrier_sweep_max(ev[5]),
		.afc_success(ev[4]), .afc_fail(ev[3]), .next_freq_search(ev[2]),
		.same_freq_search(ev[1]), .loop_limit(ev[0]), .scan_start(scan_go),
		.search_rates(srch), .subrange_select(sel12), .sweep_done(swp),
		.symbol_rate_readout(srate), .inphase_offset(dci), .quadrature_offset(dcq),
		.decimation_index(dec), .freq_detector_value(fld), .timing_detector_value(tld),
		.phase_detector_value(pld), .symbol_i(sym_i), .symbol_q(sym_q),
		.demod_full_lock(full_lock), .carrier_timing_lock(ct_lock), .resume_search(resume),
		.active_subrange(act), .freq_restart(frs), .irq_n(irq_n));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic chk1(input string nm, input logic exp, input logic got);
		chk(nm, {15'h0000, exp}, {15'h0000, got});
	endtask : chk1

	task automatic rdc(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e,
		input string nm);
		logic [7:0] d;
		logic       v;
		u_host.rd(a, d, v);
		chk1({nm, " valid"}, 1'b1, v);
		chk(nm, {8'h00, e}, {8'h00, d & m});
	endtask : rdc

	task automatic rd16(input logic [6:0] a, input logic [15:0] e, input string nm);
		rdc(a, 8'hFF, e[15:8], nm);
		rdc(a + 7'h01, 8'hFF, e[7:0], nm);
	endtask : rd16

	task automatic clr();
		logic [7:0] d;
		logic       v;
		for (int i = 0; i < 3; i++) u_host.rd(7'(i), d, v);
	endtask : clr

	task automatic pulse(input logic [7:0] m);
		@(negedge clk);
		ev = m;
		@(negedge clk);
		ev = 8'h00;
	endtask : pulse

	task automatic sweep();
		@(negedge clk);
		swp = 1'b1;
		#1;
		chk1("restart pulse", 1'b1, frs);
		@(negedge clk);
		swp = 1'b0;
	endtask : sweep

	task automatic t_reset();
		logic [6:0] a [10] = '{`QDSR_ADR_EV_HIGH, `QDSR_ADR_EV_MID, `QDSR_ADR_EV_LOW,
			`QDSR_ADR_ST_HIGH, `QDSR_ADR_ST_LOW, `QDSR_ADR_SR_HIGH, `QDSR_ADR_SR_LOW,
			`QDSR_ADR_PV_HIGH, `QDSR_ADR_PV_LOW, 7'h40};
		chk1("irq idle", 1'b1, irq_n);
		foreach (a[i]) rdc(a[i], 8'hFF, `QDSR_RST_BYTE, "reset value");
	endtask : t_reset

	task automatic t_events();
		clr();
		pulse(8'hE0);
		rdc(`QDSR_ADR_EV_MID, 8'hFF, 8'h07, "mid events");
		rdc(`QDSR_ADR_EV_MID, 8'hFF, 8'h00, "mid cleared");
		pulse(8'h1F);
		rdc(`QDSR_ADR_EV_LOW, 8'hFF, 8'h1F, "low events");
		fork
			rdc(`QDSR_ADR_EV_MID, 8'hFF, 8'h00, "read with event");
			pulse(8'h80);
		join
		rdc(`QDSR_ADR_EV_MID, 8'hFF, 8'h04, "event kept");
	endtask : t_events

	task automatic t_levels();
		clr();
		@(negedge clk) lv = 10'h3FE;
		repeat (3) @(negedge clk);
		rdc(`QDSR_ADR_ST_HIGH, 8'hFF, 8'hFC, "status high");
		rdc(`QDSR_ADR_ST_LOW, 8'hFF, 8'hC0, "status low");
		@(negedge clk) lv = 10'h000;
		repeat (3) @(negedge clk);
		rdc(`QDSR_ADR_EV_HIGH, 8'hFF, 8'h0F, "lock edges");
		rdc(`QDSR_ADR_EV_MID, 8'hFF, 8'hF8, "gain edges");
		rdc(`QDSR_ADR_ST_LOW, 8'hFF, 8'h00, "status low idle");
	endtask : t_levels

	task automatic t_lock();
		int         n;
		int         lo;
		int         hi;
		logic [7:0] lims [2] = '{8'h02, 8'h00};
		clr();
		@(negedge clk) ct_acq = 1'b1;
		@(negedge clk);
		chk1("ct lock", 1'b1, ct_lock);
		chk1("full lock early", 1'b0, full_lock);
		@(negedge clk) dec_lock = 1'b1;
		@(negedge clk);
		chk1("full lock", 1'b1, full_lock);
		rdc(`QDSR_ADR_EV_HIGH, 8'hA0, 8'hA0, "lock events");
		rdc(`QDSR_ADR_ST_HIGH, 8'h01, 8'h01, "status full lock");
		rdc(`QDSR_ADR_EV_LOW, 8'h80, 8'h80, "state change");
		@(negedge clk) {ct_acq, dec_lock} = 2'b00;
		repeat (3) @(negedge clk);
		chk1("full lock lost", 1'b0, full_lock);
		rdc(`QDSR_ADR_EV_HIGH, 8'h10, 8'h10, "unlock event");
		foreach (lims[k]) begin
			lim = lims[k];
			lo = int'(lim) * `QDSR_LOCK_TICK_CYC;
			hi = lo + `QDSR_LOCK_TICK_CYC;
			@(negedge clk) ct_acq = 1'b1;
			n = 0;
			while (resume !== 1'b1 && n < 200) begin
				@(negedge clk);
				n++;
			end
			ct_acq = 1'b0;
			chk1("timeout span", 1'b1, n > lo && n <= hi);
			@(negedge clk);
			chk1("ct lock dropped", 1'b0, ct_lock);
		end
	endtask : t_lock

	task automatic t_scan();
		clr();
		@(negedge clk) sel12 = 12'hA00;
		srch = 1'b1;
		scan_go = 1'b1;
		@(negedge clk) scan_go = 1'b0;
		chk("first range", 16'h000B, {12'h000, act});
		sweep();
		chk("next range", 16'h0009, {12'h000, act});
		rdc(`QDSR_ADR_EV_LOW, 8'h60, 8'h40, "range end");
		sweep();
		chk("wrap range", 16'h000B, {12'h000, act});
		rdc(`QDSR_ADR_EV_LOW, 8'h60, 8'h60, "rate end");
		srch = 1'b0;
		sweep();
		chk("known rate", 16'h000B, {12'h000, act});
		rdc(`QDSR_ADR_EV_LOW, 8'h60, 8'h40, "no rate end");
	endtask : t_scan

	task automatic t_probe();
		logic [3:0]  s [7] = '{4'h1, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8};
		logic [15:0] e [7] = '{16'hFD12, 16'hA000, 16'h3C3C, 16'h1234, 16'h1234,
			16'hA5C3, 16'hA5C3};
		{srate, dci, dcq, dec, fld} = {16'hC3A7, 8'hFD, 8'h12, 3'h5, 8'h3C};
		{tld, pld, sym_i, sym_q} = {16'h1234, 16'hA5C3, 8'h71, 8'h0E};
		rd16(`QDSR_ADR_SR_HIGH, 16'hC3A7, "symbol rate");
		chk("rate setting", 16'h30E9, {2'b00, u_host.rate_setting(srate)});
		foreach (s[i]) begin
			u_host.wr(`QDSR_ADR_PROBE_SEL, {4'h0, s[i]});
			rd16(`QDSR_ADR_PV_HIGH, e[i], "probe");
		end
		rdc(`QDSR_ADR_PROBE_SEL, 8'hFF, 8'h08, "probe select");
		u_host.wr(`QDSR_ADR_PROBE_SEL, {4'h0, `QDSR_SEL_IQ});
		rdc(`QDSR_ADR_PV_HIGH, 8'hFF, 8'h71, "snapshot i");
		sym_q = 8'h99;
		rdc(`QDSR_ADR_PV_LOW, 8'hFF, 8'h0E, "snapshot q");
	endtask : t_probe

	task automatic t_irq();
		clr();
		pulse(8'h01);
		repeat (2) @(negedge clk);
		chk1("irq masked", 1'b1, irq_n);
		rdc(`QDSR_ADR_EV_LOW, 8'hFF, 8'h01, "masked event kept");
		u_host.wr(`QDSR_ADR_IE_LOW, 8'h01);
		rdc(`QDSR_ADR_IE_LOW, 8'hFF, 8'h01, "enable readback");
		pulse(8'h01);
		repeat (2) @(negedge clk);
		chk1("irq raised", 1'b0, irq_n);
		rdc(`QDSR_ADR_EV_LOW, 8'hFF, 8'h01, "enabled event");
		repeat (2) @(negedge clk);
		chk1("irq cleared", 1'b1, irq_n);
	endtask : t_irq

	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_of_test();
	end

	initial begin
		{rst_n, ct_acq, dec_lock, srch, scan_go, swp, sel12, ev, lv} = '0;
		{dci, dcq, fld, sym_i, sym_q, srate, tld, pld, dec} = '0;
		lim = 8'h02;
		repeat (3) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		t_reset();
		t_events();
		t_levels();
		t_lock();
		t_scan();
		t_probe();
		t_irq();
		end_of_test();
	end
endmodule : qdsr_status_test
